// [pkg/mcr_pkg.sv]
// mcr_pkg: constants and carrier types of the motion command register bank
// assumes: a protocol layer delivers one decoded register or bit request per cycle
`default_nettype none

package mcr_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned POS_W  = 6;

    // word addresses
    localparam logic [15:0] ADDR_CTRL_WORD   = 16'h0D00;
    localparam logic [15:0] ADDR_POS_SELECT  = 16'h0D03;
    localparam logic [15:0] ADDR_POS_DIRECT  = 16'h9800;

    // bit addresses of the control word
    localparam logic [15:0] BADDR_REDUCED_SPEED = 16'h0401;
    localparam logic [15:0] BADDR_SERVO         = 16'h0403;
    localparam logic [15:0] BADDR_ALARM_CLEAR   = 16'h0407;
    localparam logic [15:0] BADDR_PAUSE         = 16'h040A;
    localparam logic [15:0] BADDR_HOME          = 16'h040B;
    localparam logic [15:0] BADDR_MOVE          = 16'h040C;
    // bit addresses of the position select word, bit 5 first
    localparam logic [15:0] BADDR_POSNUM_BIT5   = 16'h043A;
    localparam logic [15:0] BADDR_POSNUM_BIT0   = 16'h043F;

    // control word bit positions
    localparam int unsigned BIT_REDUCED_SPEED = 14;
    localparam int unsigned BIT_SERVO         = 12;
    localparam int unsigned BIT_ALARM_CLEAR   = 8;
    localparam int unsigned BIT_PAUSE         = 5;
    localparam int unsigned BIT_HOME          = 4;
    localparam int unsigned BIT_MOVE          = 3;

    localparam logic [15:0] CTRL_MASK  = 16'h5138;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [5:0]  POS_RESET  = 6'h00;
    localparam logic [15:0] ZERO_WORD  = 16'h0000;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        bit_access;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mcr_req_t;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [15:0] rdata;
    } mcr_rsp_t;

    typedef struct packed {
        logic       reduced_speed_select;
        logic       servo_energize;
        logic       pause_hold;
        logic       alarm_clear_edge;
        logic       home_launch_edge;
        logic       move_launch_edge;
        logic [5:0] move_position;
    } mcr_cmd_t;

endpackage : mcr_pkg

`default_nettype wire

// [hw/mcr_edge_detect.sv]
// mcr_edge_detect: per-bit zero-to-one detector over a register word
// assumes: input is a registered word in the same clock domain
`timescale 1ns/1ps
`default_nettype none

module mcr_edge_detect #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] rise_out
);

    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } mcr_edge_state_t;

    mcr_edge_state_t state_q;
    mcr_edge_state_t state_d;

    always_comb begin
        state_d      = state_q;
        state_d.prev = level_in;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            assign rise_out[gi] = level_in[gi] & ~state_q.prev[gi];
        end
    endgenerate

endmodule : mcr_edge_detect

`default_nettype wire

// [hw/mcr_command_bank.sv]
// mcr_command_bank: control word and position select registers of the actuator controller
// assumes: the serial protocol layer hands over one decoded request per enabled cycle
`timescale 1ns/1ps
`default_nettype none

module mcr_command_bank (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              numeric_mode,
    input  wire mcr_pkg::mcr_req_t req,
    output mcr_pkg::mcr_rsp_t      rsp,
    output mcr_pkg::mcr_cmd_t      cmd
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [15:0] ctrl;
        logic [5:0]  pos;
        logic [5:0]  dpos;
        logic [5:0]  target;
        logic        clear_p;
        logic        home_p;
        logic        move_p;
        logic        rsp_valid;
        logic        rsp_error;
        logic [15:0] rsp_data;
    } mcr_bank_state_t;

    mcr_bank_state_t state_q;
    mcr_bank_state_t state_d;
    logic [15:0]     rise_w;

    mcr_edge_detect #(
        .WIDTH    (mcr_pkg::DATA_W)
    ) u_edge (
        .clock    (clock),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .level_in (state_q.ctrl),
        .rise_out (rise_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request decode

    logic       hit_ctrl;
    logic       hit_pos;
    logic       hit_dpos;
    logic       hit_cbit;
    logic       hit_pbit;
    logic [3:0] cbit_idx;
    logic [2:0] pbit_idx;
    logic       direct_wr;

    always_comb begin
        hit_ctrl = req.valid && !req.bit_access && req.addr == mcr_pkg::ADDR_CTRL_WORD;
        hit_pos  = req.valid && !req.bit_access && req.addr == mcr_pkg::ADDR_POS_SELECT;
        hit_dpos = req.valid && !req.bit_access && req.addr == mcr_pkg::ADDR_POS_DIRECT;
        hit_cbit = req.valid && req.bit_access;
        cbit_idx = 4'h0;
        case (req.addr)
            mcr_pkg::BADDR_REDUCED_SPEED: cbit_idx = 4'(mcr_pkg::BIT_REDUCED_SPEED);
            mcr_pkg::BADDR_SERVO:         cbit_idx = 4'(mcr_pkg::BIT_SERVO);
            mcr_pkg::BADDR_ALARM_CLEAR:   cbit_idx = 4'(mcr_pkg::BIT_ALARM_CLEAR);
            mcr_pkg::BADDR_PAUSE:         cbit_idx = 4'(mcr_pkg::BIT_PAUSE);
            mcr_pkg::BADDR_HOME:          cbit_idx = 4'(mcr_pkg::BIT_HOME);
            mcr_pkg::BADDR_MOVE:          cbit_idx = 4'(mcr_pkg::BIT_MOVE);
            default:                      hit_cbit = 1'b0;
        endcase
        // position bits count down: lowest address is bit 5
        hit_pbit = req.valid && req.bit_access
                   && req.addr >= mcr_pkg::BADDR_POSNUM_BIT5
                   && req.addr <= mcr_pkg::BADDR_POSNUM_BIT0;
        pbit_idx = 3'(mcr_pkg::BADDR_POSNUM_BIT0 - req.addr);
        // direct start only in position-number mode
        direct_wr = hit_dpos && req.write && !numeric_mode;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_d           = state_q;
        state_d.rsp_valid = req.valid;
        state_d.rsp_error = 1'b0;
        state_d.rsp_data  = mcr_pkg::ZERO_WORD;
        if (hit_ctrl) begin
            if (req.write) begin
                state_d.ctrl = req.wdata & mcr_pkg::CTRL_MASK;
            end
            state_d.rsp_data = state_q.ctrl;
        end else if (hit_pos) begin
            if (req.write) begin
                state_d.pos = req.wdata[5:0];
            end
            state_d.rsp_data = {10'h000, state_q.pos};
        end else if (hit_dpos) begin
            if (req.write) begin
                state_d.dpos = req.wdata[5:0];
            end
            state_d.rsp_data = {10'h000, state_q.dpos};
        end else if (hit_cbit) begin
            if (req.write) begin
                state_d.ctrl[cbit_idx] = req.wdata[0];
            end
            state_d.rsp_data = {15'h0000, state_q.ctrl[cbit_idx]};
        end else if (hit_pbit) begin
            if (req.write) begin
                state_d.pos[pbit_idx] = req.wdata[0];
            end
            state_d.rsp_data = {15'h0000, state_q.pos[pbit_idx]};
        end else begin
            state_d.rsp_error = req.valid;
        end

        // pulses live one enabled cycle; levels pass straight from the register
        state_d.clear_p = rise_w[mcr_pkg::BIT_ALARM_CLEAR];
        state_d.home_p  = rise_w[mcr_pkg::BIT_HOME];
        state_d.move_p  = rise_w[mcr_pkg::BIT_MOVE] || direct_wr;
        // a direct write is the newer command, so it wins the target
        if (direct_wr) begin
            state_d.target = req.wdata[5:0];
        end else if (rise_w[mcr_pkg::BIT_MOVE]) begin
            state_d.target = state_q.pos;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q      <= '0;
            state_q.ctrl <= mcr_pkg::CTRL_RESET;
            state_q.pos  <= mcr_pkg::POS_RESET;
            state_q.dpos <= mcr_pkg::POS_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        rsp.valid                = state_q.rsp_valid;
        rsp.error                = state_q.rsp_error;
        rsp.rdata                = state_q.rsp_data;
        cmd.reduced_speed_select = state_q.ctrl[mcr_pkg::BIT_REDUCED_SPEED];
        cmd.servo_energize       = state_q.ctrl[mcr_pkg::BIT_SERVO];
        cmd.pause_hold           = state_q.ctrl[mcr_pkg::BIT_PAUSE];
        cmd.alarm_clear_edge     = state_q.clear_p;
        cmd.home_launch_edge     = state_q.home_p;
        cmd.move_launch_edge     = state_q.move_p;
        cmd.move_position        = state_q.target;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_ctrl_unused_zero: assert property ((state_q.ctrl & ~mcr_pkg::CTRL_MASK) == 16'h0000)
        else $error("unassigned control bit set");

    chk_servo_follows: assert property (
        clk_en && hit_cbit && req.write && req.addr == mcr_pkg::BADDR_SERVO
        |=> cmd.servo_energize == $past(req.wdata[0]))
        else $error("servo bit write not applied");

    chk_speed_follows: assert property (
        clk_en && hit_ctrl && req.write
        |=> cmd.reduced_speed_select == $past(req.wdata[mcr_pkg::BIT_REDUCED_SPEED]))
        else $error("reduced speed not taken from word write");

    // checked against the written word, not the register, so a broken mask shows up
    chk_pause_follows: assert property (
        clk_en && hit_ctrl && req.write
        |=> cmd.pause_hold == $past(req.wdata[mcr_pkg::BIT_PAUSE]))
        else $error("pause output differs from written control bit");

    chk_clear_on_rise: assert property (
        clk_en && $past(clk_en) |-> cmd.alarm_clear_edge == $past(rise_w[mcr_pkg::BIT_ALARM_CLEAR]))
        else $error("alarm clear not tied to rising edge");

    chk_clear_level: assert property (
        clk_en && state_q.ctrl[mcr_pkg::BIT_ALARM_CLEAR] ##1 clk_en && state_q.ctrl[mcr_pkg::BIT_ALARM_CLEAR]
        ##1 clk_en |-> !cmd.alarm_clear_edge)
        else $error("alarm clear on steady level");

    chk_home_on_rise: assert property (
        clk_en && rise_w[mcr_pkg::BIT_HOME] |=> cmd.home_launch_edge)
        else $error("home launch missed");

    chk_move_on_rise: assert property (
        clk_en && rise_w[mcr_pkg::BIT_MOVE] && !direct_wr
        |=> cmd.move_launch_edge && cmd.move_position == $past(state_q.pos))
        else $error("move launch or target wrong");

    chk_pos_nostart: assert property (
        clk_en && hit_pos && req.write && !rise_w[mcr_pkg::BIT_MOVE] |=> !cmd.move_launch_edge)
        else $error("position select write started motion");

    chk_direct_start: assert property (
        clk_en && direct_wr
        |=> cmd.move_launch_edge && cmd.move_position == $past(req.wdata[5:0]))
        else $error("direct position write did not start");

    chk_numeric_gate: assert property (
        clk_en && hit_dpos && req.write && numeric_mode && !rise_w[mcr_pkg::BIT_MOVE] |=> !cmd.move_launch_edge)
        else $error("direct start in numeric mode");

    chk_pos_readback: assert property (
        clk_en && (hit_pos || hit_dpos) && !req.write |=> rsp.valid && rsp.rdata[15:6] == 10'h000)
        else $error("position readback upper bits set");

    cov_direct_move: cover property (clk_en && direct_wr ##1 cmd.move_launch_edge);
    cov_alarm_clear: cover property (cmd.alarm_clear_edge);
    cov_unmapped:    cover property (rsp.valid && rsp.error);
    cov_edge_move:   cover property (clk_en && rise_w[mcr_pkg::BIT_MOVE] ##1 cmd.move_launch_edge);

endmodule : mcr_command_bank

`default_nettype wire

// [bench/mcr_plc_model.sv]
// mcr_plc_model: serial master in front of the command bank, one decoded request at a time
// assumes: the bank answers every request one clock after it is taken
`timescale 1ns/1ps
`default_nettype none

module mcr_plc_model (
    input  wire logic              clock,
    input  wire mcr_pkg::mcr_rsp_t rsp,
    output mcr_pkg::mcr_req_t      req
);
    initial req = '0;

    // the bench loads the position number first and raises the start bit afterwards
    task automatic xfer(input logic wr, input logic bacc, input logic [15:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic err);
        @(posedge clock);
        #2;
        req = '{valid: 1'b1, write: wr, bit_access: bacc, addr: addr, wdata: wdata};
        @(posedge clock);
        #2;
        // released lines show the inverse so stale values never look valid
        req = '{valid: 1'b0, write: ~wr, bit_access: ~bacc, addr: ~addr, wdata: ~wdata};
        rdata = rsp.rdata;
        err = (rsp.valid === 1'b1) ? rsp.error : 1'bx;
    endtask
endmodule // mcr_plc_model

`default_nettype wire

// [bench/test_motion_command_register_bank.sv]
// test_motion_command_register_bank: directed checks of the command bank through word and bit requests
// assumes: clk_en held high except for one edge before the numeric start; expectations follow the one-cycle answer of the register port
`timescale 1ns/1ps
`default_nettype none

module test_motion_command_register_bank;
    logic              clock;
    logic              reset_n;
    logic              clk_en;
    logic              numeric_mode;
    mcr_pkg::mcr_req_t req;
    mcr_pkg::mcr_rsp_t rsp;
    mcr_pkg::mcr_cmd_t cmd;
    logic [15:0]       rdata;
    logic              err;
    int                n_mismatch;
    int                checked;
    int                cycles = 0;
    logic [15:0]       baddr [6];
    int                bpos [6];

    mcr_command_bank dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .numeric_mode(numeric_mode),
                          .req(req), .rsp(rsp), .cmd(cmd));
    mcr_plc_model plc (.clock(clock), .rsp(rsp), .req(req));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a hang costs at most this many cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b = 1'b0);
        plc.xfer(1'b1, b, a, d, rdata, err);
        chk({15'h0000, err}, 16'h0000, "write answer");
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic b = 1'b0);
        plc.xfer(1'b0, b, a, 16'h0000, rdata, err);
        chk(rdata, exp, "read");
        chk({15'h0000, err}, 16'h0000, "read answer");
    endtask

    task automatic step;
        @(posedge clock);
        #2;
    endtask

    // pulses as {alarm, home, move}, levels as {speed, servo, pause}
    task automatic pulses(input logic [2:0] exp);
        chk({13'h0000, cmd.alarm_clear_edge, cmd.home_launch_edge, cmd.move_launch_edge}, {13'h0000, exp}, "pulses");
    endtask

    task automatic levels(input logic [2:0] exp);
        chk({13'h0000, cmd.reduced_speed_select, cmd.servo_energize, cmd.pause_hold}, {13'h0000, exp}, "levels");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        numeric_mode = 1'b0;
        clk_en = 1'b1;
        n_mismatch = 0;
        checked = 0;
        baddr = '{mcr_pkg::BADDR_REDUCED_SPEED, mcr_pkg::BADDR_SERVO, mcr_pkg::BADDR_ALARM_CLEAR,
                  mcr_pkg::BADDR_PAUSE, mcr_pkg::BADDR_HOME, mcr_pkg::BADDR_MOVE};
        bpos = '{14, 12, 8, 5, 4, 3};
        repeat (20) @(posedge clock);
        #2;
        reset_n = 1'b1;
        chk({4'h0, cmd}, 16'h0000, "reset outputs");
        rd(mcr_pkg::ADDR_CTRL_WORD, 16'h0000);
        rd(mcr_pkg::ADDR_POS_SELECT, 16'h0000);
        rd(mcr_pkg::ADDR_POS_DIRECT, 16'h0000);
        wr(mcr_pkg::ADDR_CTRL_WORD, 16'hFFFF);
        step;
        levels(3'b111);
        pulses(3'b111);
        step;
        pulses(3'b000);
        wr(mcr_pkg::ADDR_CTRL_WORD, 16'hFFFF);
        step;
        pulses(3'b000);
        rd(mcr_pkg::ADDR_CTRL_WORD, 16'h5138);
        wr(mcr_pkg::ADDR_CTRL_WORD, 16'h0000);
        step;
        levels(3'b000);
        foreach (baddr[i]) begin
            wr(baddr[i], 16'h0001, 1'b1);
            rd(mcr_pkg::ADDR_CTRL_WORD, 16'h0001 << bpos[i]);
            rd(baddr[i], 16'h0001, 1'b1);
            wr(baddr[i], 16'h0000, 1'b1);
        end
        wr(mcr_pkg::ADDR_POS_SELECT, 16'hFFC5);
        // a wrong launch would stand right after the write, so look before the read
        pulses(3'b000);
        rd(mcr_pkg::ADDR_POS_SELECT, 16'h0005);
        wr(mcr_pkg::ADDR_CTRL_WORD, 16'h0008);
        step;
        pulses(3'b001);
        chk({10'h000, cmd.move_position}, 16'h0005, "move target");
        wr(mcr_pkg::ADDR_CTRL_WORD, 16'h0000);
        wr(mcr_pkg::ADDR_POS_SELECT, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            wr(mcr_pkg::BADDR_POSNUM_BIT5 + 16'(i), 16'h0001, 1'b1);
            rd(mcr_pkg::ADDR_POS_SELECT, 16'h0020 >> i);
            wr(mcr_pkg::BADDR_POSNUM_BIT5 + 16'(i), 16'h0000, 1'b1);
        end
        wr(mcr_pkg::ADDR_POS_DIRECT, 16'hFFC9);
        pulses(3'b001);
        chk({10'h000, cmd.move_position}, 16'h0009, "direct target");
        rd(mcr_pkg::ADDR_POS_DIRECT, 16'h0009);
        numeric_mode = 1'b1;
        wr(mcr_pkg::ADDR_POS_DIRECT, 16'h0011);
        pulses(3'b000);
        step;
        chk({10'h000, cmd.move_position}, 16'h0009, "held target");
        wr(mcr_pkg::ADDR_CTRL_WORD, 16'h0008);
        // a low enable must hold the launch back until the next enabled edge
        clk_en = 1'b0;
        step;
        pulses(3'b000);
        clk_en = 1'b1;
        step;
        pulses(3'b001);
        chk({10'h000, cmd.move_position}, 16'h0000, "numeric start");
        numeric_mode = 1'b0;
        plc.xfer(1'b1, 1'b1, 16'h0402, 16'h0001, rdata, err);
        chk({15'h0000, err}, 16'h0001, "unmapped bit");
        plc.xfer(1'b0, 1'b0, 16'h1234, 16'h0000, rdata, err);
        chk({15'h0000, err}, 16'h0001, "unmapped word");
        chk(rdata, 16'h0000, "unmapped word data");
        rd(mcr_pkg::ADDR_CTRL_WORD, 16'h0008);
        conclude();
    end
endmodule // test_motion_command_register_bank

`default_nettype wire
